// ### rtl/pplk_lock.sv
/*
   parameter password lock: holds the lock level and password entry,
   judges every parameter access, clear, all-clear and copy, counts
   failed unlock attempts at the extended lock levels.
   assumes all inputs come from logic on ref_clk; register port reads
   answer one cycle after the read strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module pplk_lock
   import pplk_pkg::*;
(
   input wire logic ref_clk, // 125 MHz
   input wire logic rst_n, // sync reset
   input wire logic [pplk_pkg::PPLK_AW-1:0] reg_addr, // byte address
   input wire logic [pplk_pkg::PPLK_DW-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [pplk_pkg::PPLK_DW-1:0] reg_rdata, // read data
   input wire logic ext_display_all, // extended_display_select is 0
   input wire logic write_protect_ok, // write_protect_select permits write
   input wire logic [2:0] panel_source_select, // panel command source
   input wire logic motor_running, // drive running
   input wire logic panel_unit_attached, // parameter unit fitted
   input wire logic chk_valid, // access check request
   input wire logic [2:0] chk_kind, // param, clear, all-clear, copy
   input wire logic chk_write, // 1 write, 0 read
   input wire logic chk_rs485, // access arrived over RS-485
   input wire logic net_mode, // network operation mode
   input wire logic chk_ext, // parameter is extended
   input wire logic chk_self, // device writes for itself
   output logic chk_done, // check answered
   output logic chk_grant, // access allowed
   output logic lock_error_disp, // lock error shown
   output logic all_clear_go, // perform all-clear
   output logic locked, // password registered
   output logic lockout, // fifth error reached
   output logic panel_jog_disable, // panel jog blocked
   output logic easy_mode_disable // easy-mode switching blocked
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [PPLK_DW-1:0] level_reg;
   logic [PPLK_DW-1:0] pwd_reg;
   logic registered_reg;
   logic [2:0] err_reg;
   logic refused_reg;
   logic [PPLK_DW-1:0] rdata_reg;
   logic done_reg;
   logic grant_reg;
   logic lock_err_reg;
   logic clear_go_reg;
   logic jog_dis_reg;
   logic easy_dis_reg;
   logic lockout_reg;

   // ------------------------------------------------------------
   // decode of the level
   // ------------------------------------------------------------
   logic level_ext;
   logic level_set;
   logic [2:0] digit;
   logic blk_pr;
   logic blk_pw;
   logic blk_nr;
   logic blk_nw;
   logic is_lockout;

   function automatic logic level_valid(input logic [PPLK_DW-1:0] v);
      level_valid = (v == PPLK_NO_LOCK) ||
                    (v >= PPLK_LVL_MIN && v <= PPLK_LVL_MAX) ||
                    (v >= PPLK_LVLX_MIN && v <= PPLK_LVLX_MAX);
   endfunction : level_valid

   always_comb
   begin
      level_set = (level_reg != PPLK_NO_LOCK);
      level_ext = (level_reg >= PPLK_LVLX_MIN) && (level_reg <= PPLK_LVLX_MAX);
      if (level_ext)
      begin
         digit = 3'(level_reg - PPLK_LVLX_BASE);
      end
      else
      begin
         digit = level_reg[2:0];
      end
      blk_pr = registered_reg && (digit == 3'h4 || digit == 3'h5);
      blk_nr = registered_reg && (digit == 3'h4 || digit == 3'h6);
      blk_pw = registered_reg && (digit == 3'h1 || digit == 3'h2 || digit == 3'h4 || digit == 3'h5);
      blk_nw = registered_reg && (digit == 3'h1 || digit == 3'h3 || digit == 3'h4 || digit == 3'h6);
      is_lockout = registered_reg && level_ext && (err_reg == PPLK_ERR_MAX);
   end

   // ------------------------------------------------------------
   // access check
   // ------------------------------------------------------------
   logic net_path;
   logic pw_ok;
   logic ext_ok;
   logic wp_ok;
   logic grant_next;
   logic lock_err_next;
   logic clear_next;

   always_comb
   begin
      net_path = chk_rs485 && net_mode;
      pw_ok = 1'b1;
      ext_ok = 1'b1;
      wp_ok = 1'b1;
      grant_next = 1'b0;
      lock_err_next = 1'b0;
      clear_next = 1'b0;
      case (chk_kind)
         PPLK_KIND_PARAM:
         begin
            if (chk_write)
            begin
               pw_ok = net_path ? !blk_nw : !blk_pw;
               wp_ok = write_protect_ok;
            end
            else
            begin
               pw_ok = net_path ? !blk_nr : !blk_pr;
               // rs485 reads see extended parameters unless panel source is 2
               ext_ok = !chk_ext || ext_display_all ||
                        (chk_rs485 && panel_source_select != PPLK_PANEL_SRC_PANEL_ONLY);
            end
            if (chk_self)
            begin
               grant_next = 1'b1;
            end
            else
            begin
               grant_next = pw_ok && ext_ok && wp_ok;
               lock_err_next = !pw_ok;
            end
         end
         PPLK_KIND_CLEAR, PPLK_KIND_COPY:
         begin
            pw_ok = !registered_reg;
            grant_next = pw_ok && write_protect_ok;
            lock_err_next = !pw_ok;
         end
         PPLK_KIND_ALLCLEAR:
         begin
            grant_next = !motor_running && write_protect_ok;
            clear_next = grant_next;
         end
         default:
         begin
            grant_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         done_reg <= 1'b0;
         grant_reg <= 1'b0;
         lock_err_reg <= 1'b0;
         clear_go_reg <= 1'b0;
      end
      else
      begin
         done_reg <= chk_valid;
         clear_go_reg <= chk_valid && clear_next;
         if (chk_valid)
         begin
            grant_reg <= grant_next;
            lock_err_reg <= lock_err_next;
         end
      end
   end

   // ------------------------------------------------------------
   // lock level, password and error count
   // ------------------------------------------------------------
   logic wr_level;
   logic wr_pwd;
   logic do_clear;

   always_comb
   begin
      wr_level = reg_wr && (reg_addr == PPLK_OFF_LOCK_LEVEL);
      wr_pwd = reg_wr && (reg_addr == PPLK_OFF_PASSWORD);
      do_clear = chk_valid && clear_next;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         level_reg <= PPLK_NO_LOCK;
         pwd_reg <= PPLK_NO_LOCK;
         registered_reg <= 1'b0;
         err_reg <= 3'h0;
         refused_reg <= 1'b0;
      end
      else if (do_clear)
      begin
         level_reg <= PPLK_NO_LOCK;
         pwd_reg <= PPLK_NO_LOCK;
         registered_reg <= 1'b0;
         err_reg <= 3'h0;
         refused_reg <= 1'b0;
      end
      else if (wr_level)
      begin
         if (!registered_reg && ext_display_all && level_valid(reg_wdata))
         begin
            level_reg <= reg_wdata;
            refused_reg <= 1'b0;
         end
         else
         begin
            refused_reg <= 1'b1;
         end
      end
      else if (wr_pwd)
      begin
         if (!level_set)
         begin
            refused_reg <= 1'b1;
         end
         else if (!registered_reg)
         begin
            if (reg_wdata >= PPLK_PWD_MIN && reg_wdata <= PPLK_PWD_MAX)
            begin
               pwd_reg <= reg_wdata;
               registered_reg <= 1'b1;
               err_reg <= 3'h0;
               refused_reg <= 1'b0;
            end
            else
            begin
               refused_reg <= 1'b1;
            end
         end
         else if (reg_wdata == pwd_reg && !is_lockout)
         begin
            pwd_reg <= PPLK_NO_LOCK;
            registered_reg <= 1'b0;
            err_reg <= 3'h0;
            refused_reg <= 1'b0;
         end
         else
         begin
            refused_reg <= 1'b1;
            if (level_ext && err_reg != PPLK_ERR_MAX)
            begin
               err_reg <= err_reg + 3'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // lockout flag
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || do_clear)
      begin
         lockout_reg <= 1'b0;
      end
      else if (wr_pwd && registered_reg && level_ext && reg_wdata != pwd_reg)
      begin
         // set by the fifth wrong entry, held until all-clear
         lockout_reg <= lockout_reg || (err_reg == PPLK_ERR_MAX - 3'h1);
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rdata_reg <= '0;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            PPLK_OFF_LOCK_LEVEL:
            begin
               rdata_reg <= level_reg;
            end
            PPLK_OFF_PASSWORD:
            begin
               if (registered_reg)
               begin
                  rdata_reg <= level_ext ? {13'h0, err_reg} : '0;
               end
               else
               begin
                  rdata_reg <= PPLK_NO_LOCK;
               end
            end
            PPLK_OFF_STATUS:
            begin
               rdata_reg <= '0;
               rdata_reg[PPLK_ST_ERR_LSB +: 3] <= level_ext ? err_reg : 3'h0;
               rdata_reg[PPLK_ST_LOCKED] <= registered_reg;
               rdata_reg[PPLK_ST_LOCKOUT] <= is_lockout;
               rdata_reg[PPLK_ST_REFUSED] <= refused_reg;
            end
            default:
            begin
               rdata_reg <= '0;
            end
         endcase
      end
      else
      begin
         rdata_reg <= '0;
      end
   end

   // ------------------------------------------------------------
   // mode side effects
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         jog_dis_reg <= 1'b0;
         easy_dis_reg <= 1'b0;
      end
      else
      begin
         jog_dis_reg <= blk_pr && panel_unit_attached;
         easy_dis_reg <= blk_pw;
      end
   end

   assign reg_rdata = rdata_reg;
   assign chk_done = done_reg;
   assign chk_grant = grant_reg;
   assign lock_error_disp = lock_err_reg;
   assign all_clear_go = clear_go_reg;
   assign locked = registered_reg;
   assign lockout = lockout_reg;
   assign panel_jog_disable = jog_dis_reg;
   assign easy_mode_disable = easy_dis_reg;

endmodule : pplk_lock
`default_nettype wire

// ### rtl/pplk_pkg.sv
/*
   constants for the parameter password lock: register offsets, field
   positions, reset values, lock levels and access kinds.
   assumes a 16-bit register port and a single 125 MHz clock.
*/
package pplk_pkg;

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   localparam int PPLK_AW = 4;
   localparam int PPLK_DW = 16;
   localparam logic [PPLK_AW-1:0] PPLK_OFF_LOCK_LEVEL = 4'h0;
   localparam logic [PPLK_AW-1:0] PPLK_OFF_PASSWORD = 4'h4;
   localparam logic [PPLK_AW-1:0] PPLK_OFF_STATUS = 4'h8;

   // ------------------------------------------------------------
   // status fields
   // ------------------------------------------------------------
   localparam int PPLK_ST_ERR_LSB = 0;
   localparam int PPLK_ST_LOCKED = 4;
   localparam int PPLK_ST_LOCKOUT = 5;
   localparam int PPLK_ST_REFUSED = 6;

   // ------------------------------------------------------------
   // values
   // ------------------------------------------------------------
   localparam logic [PPLK_DW-1:0] PPLK_NO_LOCK = 16'h270f;
   localparam logic [PPLK_DW-1:0] PPLK_PWD_MIN = 16'h03e8;
   localparam logic [PPLK_DW-1:0] PPLK_PWD_MAX = 16'h270e;
   localparam logic [PPLK_DW-1:0] PPLK_LVL_MIN = 16'h0001;
   localparam logic [PPLK_DW-1:0] PPLK_LVL_MAX = 16'h0006;
   localparam logic [PPLK_DW-1:0] PPLK_LVLX_MIN = 16'h0065;
   localparam logic [PPLK_DW-1:0] PPLK_LVLX_MAX = 16'h006a;
   localparam logic [PPLK_DW-1:0] PPLK_LVLX_BASE = 16'h0064;
   localparam logic [2:0] PPLK_ERR_MAX = 3'h5;
   localparam logic [2:0] PPLK_PANEL_SRC_PANEL_ONLY = 3'h2;

   // ------------------------------------------------------------
   // access kinds on the check port
   // ------------------------------------------------------------
   localparam logic [2:0] PPLK_KIND_PARAM = 3'h0;
   localparam logic [2:0] PPLK_KIND_CLEAR = 3'h1;
   localparam logic [2:0] PPLK_KIND_ALLCLEAR = 3'h2;
   localparam logic [2:0] PPLK_KIND_COPY = 3'h3;

endpackage : pplk_pkg

// ### tb/pplk_lock_checker.sv
/* checker on the pplk_lock ports.
   assumes one clock and the bind below. */
`timescale 1ns/1ns
`default_nettype none
module pplk_lock_checker
   import pplk_pkg::*;
(
   input wire logic ref_clk, // clk
   input wire logic rst_n, // rst
   input wire logic chk_valid, // req
   input wire logic [2:0] chk_kind, // kind
   input wire logic chk_write, // wr
   input wire logic chk_self, // own
   input wire logic motor_running, // run
   input wire logic write_protect_ok, // wp
   input wire logic chk_done, // ack
   input wire logic chk_grant, // ok
   input wire logic lock_error_disp, // err
   input wire logic all_clear_go, // clr
   input wire logic locked, // lock
   input wire logic lockout // out
);
   wire logic prm = chk_valid && chk_kind == PPLK_KIND_PARAM;
   wire logic acl = chk_valid && chk_kind == PPLK_KIND_ALLCLEAR;
   wire logic clc = chk_valid && chk_kind inside {PPLK_KIND_CLEAR, PPLK_KIND_COPY};
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   chk_acg_grant: assert property (all_clear_go |-> chk_done && chk_grant)
      else $error("all-clear without grant");
   chk_acg_unlock: assert property (acl && !motor_running && write_protect_ok |=> all_clear_go && !locked)
      else $error("all-clear did not unlock");
   chk_run_refuse: assert property (acl && motor_running |=> !all_clear_go && !chk_grant)
      else $error("all-clear while running");
   chk_lockout_hold: assert property (lockout && !acl |=> lockout && locked)
      else $error("lockout released");
   chk_self_grant: assert property (prm && chk_self |=> chk_grant)
      else $error("own write denied");
   chk_wp_deny: assert property (prm && chk_write && !chk_self && !write_protect_ok |=> !chk_grant)
      else $error("write protect ignored");
   chk_open_write: assert property (prm && chk_write && !locked && write_protect_ok |=> chk_grant)
      else $error("open write denied");
   chk_clear_locked: assert property (clc && locked |=> !chk_grant && lock_error_disp)
      else $error("clear or copy while locked");
   chk_open_noerr: assert property (chk_valid && !locked |=> !lock_error_disp)
      else $error("lock error while open");
   cover property (all_clear_go);
   cover property (lockout);
   cover property (chk_done && lock_error_disp);
endmodule : pplk_lock_checker
bind pplk_lock pplk_lock_checker u_chk (.*);
`default_nettype wire

// ### tb/pplk_host.sv
/* host model: register accesses as panel or network software makes them.
   assumes read data one cycle after the read strobe. */
`timescale 1ns/1ns
`default_nettype none
module pplk_host
   import pplk_pkg::*;
(
   input wire logic ref_clk, // clk
   output logic [pplk_pkg::PPLK_AW-1:0] reg_addr, // addr
   output logic [pplk_pkg::PPLK_DW-1:0] reg_wdata, // data
   output logic reg_wr, // write
   output logic reg_rd, // read
   input wire logic [pplk_pkg::PPLK_DW-1:0] reg_rdata // answer
);
   initial
   begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // released lines show the inverse, never the last value
   task automatic wr(input logic [PPLK_AW-1:0] a, input logic [PPLK_DW-1:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [PPLK_AW-1:0] a, output logic [PPLK_DW-1:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge ref_clk);
      d = reg_rdata;
   endtask : rd
endmodule : pplk_host
`default_nettype wire

// ### tb/parameter_password_lock_tb_top.sv
/* bench for pplk_lock: integer model predicts each read and check.
   assumes the host model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module parameter_password_lock_tb_top;
   import pplk_pkg::*;
   logic ref_clk = 1'b0, rst_n = 1'b0, ext_display_all = 1'b1, write_protect_ok = 1'b1;
   logic motor_running = 1'b0, panel_unit_attached = 1'b1, chk_valid = 1'b0, chk_write = 1'b0;
   logic chk_rs485 = 1'b0, net_mode = 1'b0, chk_ext = 1'b0, chk_self = 1'b0;
   logic [2:0] panel_source_select = 3'h0, chk_kind = 3'h0;
   logic [PPLK_AW-1:0] reg_addr;
   logic [PPLK_DW-1:0] reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, chk_done, chk_grant, lock_error_disp, all_clear_go, locked, lockout;
   logic panel_jog_disable, easy_mode_disable;
   int err_total = 0, checks = 0, cyc = 0, seed = 58508, lvl = 9999, pwd, err = 0, pv, qv;
   bit rg = 0;
   int lv_q[$] = '{1, 2, 3, 4, 5, 6, 101, 102, 103, 104, 105, 106};
   always #4 ref_clk = ~ref_clk;
   pplk_lock dut (.*);
   pplk_host host (.*);
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out
   task automatic cmp(input string n, input logic [15:0] e, s);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : cmp
   task automatic rdc(input logic [PPLK_AW-1:0] a, input int e, input logic [15:0] m);
      logic [15:0] v;
      host.rd(a, v);
      cmp("register", 16'(e) & m, v & m);
   endtask : rdc
   function automatic int st;
      return int'(rg && lvl > 100 && err == 5) * 32 + int'(rg) * 16 + (lvl > 100 ? err : 0);
   endfunction : st
   task automatic wm(input logic [PPLK_AW-1:0] a, input int v);
      host.wr(a, 16'(v));
      if (a == PPLK_OFF_LOCK_LEVEL && !rg && ext_display_all && v inside {9999, [1:6], [101:106]})
         lvl = v;
      else if (a == PPLK_OFF_PASSWORD && lvl != 9999 && !rg)
      begin
         pwd = v;
         rg = 1;
      end
      else if (a == PPLK_OFF_PASSWORD && rg && v == pwd && !(lvl > 100 && err == 5))
         {rg, err} = '0;
      else if (a == PPLK_OFF_PASSWORD && rg && v != pwd && lvl > 100 && err < 5)
         err++;
   endtask : wm
   task automatic ac(input logic [2:0] k, input bit w, n, e, s, r = 1'b0);
      bit dny, eg;
      logic [6:0] m;
      @(posedge ref_clk);
      chk_valid <= 1'b1;
      {chk_kind, chk_write, chk_rs485, net_mode, chk_ext, chk_self} <= {k, w, n || r, n, e, s};
      @(posedge ref_clk);
      chk_valid <= 1'b0;
      chk_kind <= ~k;
      @(posedge ref_clk);
      m = w ? (n ? 7'h5a : 7'h36) : (n ? 7'h50 : 7'h30);
      dny = rg && k == PPLK_KIND_PARAM && !s && m[lvl % 100];
      eg = (k == PPLK_KIND_ALLCLEAR ? !motor_running : !rg) && write_protect_ok;
      if (k == PPLK_KIND_PARAM)
         eg = s || !dny && (w ? write_protect_ok : !e || ext_display_all || (n || r) && panel_source_select != 3'h2);
      cmp("done", 1, chk_done);
      cmp("grant", eg, chk_grant);
      cmp("lock error", rg && (dny || k inside {PPLK_KIND_CLEAR, PPLK_KIND_COPY}), lock_error_disp);
      cmp("clear go", k == PPLK_KIND_ALLCLEAR && eg, all_clear_go);
      if (k == PPLK_KIND_ALLCLEAR && eg)
      begin
         {rg, err} = '0;
         lvl = 9999;
      end
      cmp("locked", rg, locked);
      cmp("lockout", rg && lvl > 100 && err == 5, lockout);
   endtask : ac
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total++;
         close_out();
      end
   end
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdc(PPLK_OFF_LOCK_LEVEL, 9999, 16'hffff);
      rdc(PPLK_OFF_PASSWORD, 9999, 16'hffff);
      wm(PPLK_OFF_PASSWORD, 1234);
      rdc(PPLK_OFF_STATUS, 16'h0040, 16'h0070);
      rdc(PPLK_OFF_PASSWORD, 9999, 16'hffff);
      foreach (lv_q[i])
         wm(PPLK_OFF_LOCK_LEVEL, lv_q[i] % 100 + 6);
      rdc(PPLK_OFF_LOCK_LEVEL, 9999, 16'hffff);
      $display("test reset and refusals done");
      foreach (lv_q[i])
      begin
         panel_unit_attached <= 1'($random(seed));
         wm(PPLK_OFF_LOCK_LEVEL, lv_q[i]);
         rdc(PPLK_OFF_LOCK_LEVEL, lvl, 16'hffff);
         ac(PPLK_KIND_CLEAR, 0, 0, 0, 0);
         pv = 1000 + {$random(seed)} % 8999;
         qv = pv == 9998 ? 1000 : pv + 1;
         wm(PPLK_OFF_PASSWORD, pv);
         rdc(PPLK_OFF_PASSWORD, 0, 16'hffff);
         for (int k = 0; k < 4; k++)
            ac(PPLK_KIND_PARAM, k[0], k[1], 0, 0);
         ac(PPLK_KIND_PARAM, 1, 0, 0, 1);
         ac(PPLK_KIND_PARAM, 1, 0, 0, 0, 1);
         ac(PPLK_KIND_COPY, 0, 0, 0, 0);
         wm(PPLK_OFF_LOCK_LEVEL, 9999);
         rdc(PPLK_OFF_LOCK_LEVEL, lvl, 16'hffff);
         cmp("jog", panel_unit_attached && lvl % 100 inside {4, 5}, panel_jog_disable);
         cmp("easy", lvl % 100 inside {1, 2, 4, 5}, easy_mode_disable);
         wm(PPLK_OFF_PASSWORD, qv);
         rdc(PPLK_OFF_STATUS, st(), 16'h003f);
         wm(PPLK_OFF_PASSWORD, pv);
         rdc(PPLK_OFF_STATUS, st(), 16'h003f);
      end
      $display("test levels done");
      wm(PPLK_OFF_LOCK_LEVEL, 101);
      wm(PPLK_OFF_PASSWORD, pv);
      repeat (6)
         wm(PPLK_OFF_PASSWORD, qv);
      rdc(PPLK_OFF_PASSWORD, 5, 16'hffff);
      wm(PPLK_OFF_PASSWORD, pv);
      rdc(PPLK_OFF_STATUS, st(), 16'h003f);
      ac(PPLK_KIND_CLEAR, 0, 0, 0, 0);
      @(posedge ref_clk) motor_running <= 1'b1;
      ac(PPLK_KIND_ALLCLEAR, 0, 0, 0, 0);
      @(posedge ref_clk) motor_running <= 1'b0;
      ac(PPLK_KIND_ALLCLEAR, 0, 0, 0, 0);
      rdc(PPLK_OFF_STATUS, st(), 16'h003f);
      rdc(PPLK_OFF_LOCK_LEVEL, 9999, 16'hffff);
      $display("test lockout done");
      ac(PPLK_KIND_PARAM, 1, 1, 0, 0);
      @(posedge ref_clk) write_protect_ok <= 1'b0;
      ac(PPLK_KIND_PARAM, 1, 1, 0, 0);
      @(posedge ref_clk) write_protect_ok <= 1'b1;
      ext_display_all <= 1'b0;
      ac(PPLK_KIND_PARAM, 0, 0, 1, 0);
      ac(PPLK_KIND_PARAM, 0, 1, 1, 0);
      @(posedge ref_clk) panel_source_select <= 3'h2;
      ac(PPLK_KIND_PARAM, 0, 1, 1, 0);
      wm(PPLK_OFF_LOCK_LEVEL, 2);
      rdc(PPLK_OFF_LOCK_LEVEL, lvl, 16'hffff);
      ext_display_all <= 1'b1;
      wm(PPLK_OFF_LOCK_LEVEL, 2);
      ext_display_all <= 1'b0;
      wm(PPLK_OFF_PASSWORD, pv);
      rdc(PPLK_OFF_STATUS, st(), 16'h003f);
      $display("test qualifiers done");
      close_out();
   end
endmodule : parameter_password_lock_tb_top
`default_nettype wire
